// [rtl/sleep_mode_controller.sv]
// sleep mode controller: clock gating, wake qualification, brown-out sleep disable
`timescale 1ns/1ps
module sleep_mode_controller #(
  parameter logic [15:0] BOD_WAKE_CYCLES_P = 16'(sleep_pkg::BOD_WAKE_CYCLES), // detector wake
  parameter logic [15:0] PD_WAKE_BASE_P = sleep_pkg::PD_WAKE_BASE_CYCLES // power-down base
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // async reset, high
  input wire logic sleep_enable_bit, // from sleep_mode_control_reg
  input wire sleep_pkg::sleep_mode_t sleep_mode_select, // from sleep_mode_control_reg
  input wire logic sleep_instr, // core executes sleep, pulse
  input wire logic mcu_ctrl_wr, // mcu_control_reg write strobe
  input wire logic mcu_ctrl_wr_qualified, // timed sequence open
  input wire logic [7:0] mcu_ctrl_wdata, // mcu_control_reg write data
  input wire logic crystal_clock_sel, // crystal or resonator selected
  input wire logic [3:0] clock_select_fuses, // start-up delay choice
  input wire logic timer2_async, // timer 2 on asynchronous clock
  input wire logic adc_enabled, // converter enabled
  input wire logic comparator_disable_bit, // comparator powered down
  input wire logic [1:0] ext_irq_level_mode, // level sensing for pins a, b
  input wire logic ext_reset_pin, // external reset, async
  input wire logic ext_irq_pin_a, // external irq a request, async
  input wire logic ext_irq_pin_b, // external irq b request, async
  input wire logic pin_change_irq, // pin change request, async
  input wire logic twi_addr_match, // two_wire_iface match, async
  input wire logic watchdog_irq, // watchdog_timer interrupt
  input wire logic watchdog_reset, // watchdog_timer system reset
  input wire logic brownout_reset, // brownout_detector reset
  input wire logic timer2_irq, // timer 2 overflow or compare
  input wire logic store_ready_irq, // self_program_store or nvm ready
  input wire logic adc_done_irq, // conversion complete
  input wire logic other_irq, // any other enabled interrupt
  output logic core_clock_en, // core_clock_domain enable
  output logic program_mem_clock_en, // program_mem_clock_domain enable
  output logic io_clock_en, // io_clock_domain enable
  output logic converter_clock_en, // converter_clock_domain enable
  output logic async_timer_clock_en, // async_timer_clock_domain enable
  output logic main_osc_en, // main clock source running
  output logic timer_osc_en, // timer oscillator running
  output logic brownout_detector_en, // detector powered
  output logic brownout_sleep_disable, // readback of control bit
  output logic comparator_en, // comparator powered
  output logic adc_start, // start conversion, pulse
  output logic irq_resume, // core may take interrupt, pulse
  output logic reset_restart, // restart at reset vector, pulse
  output logic sleeping // controller not active
);
  import sleep_pkg::*;

  sleep_state_t state_q, state_d;
  sleep_mode_t mode_q;
  logic [SYNC_N-1:0] pins_s;
  logic [WAKE_N-1:0] src, mask, wake_vec;
  logic [GATE_N-1:0] gate_q, gate_d;
  logic [15:0] startup_val, pd_delay, cnt_val;
  logic cnt_load, cnt_done, go_sleep, mode_ok, wake_hit, reset_hit;
  logic wake_reset_q, bod_off_q, brownout_sleep_disable_q, bod_en_q, adc_start_q;
  logic irq_resume_q, reset_restart_q, comp_en_q, t2_ok, bod_elig;

  // clock domains left running in each sleep mode
  function automatic logic [GATE_N-1:0] gate_map(input sleep_mode_t m, input logic t2a);
    logic [GATE_N-1:0] g;
    g = '0;
    case (m)
      MODE_IDLE: begin
        g[G_IO] = 1'b1;
        g[G_ADC] = 1'b1;
        g[G_ASY] = 1'b1;
        g[G_MAIN] = 1'b1;
        g[G_TOSC] = t2a;
      end
      MODE_ADC_NR: begin
        g[G_ADC] = 1'b1;
        g[G_ASY] = 1'b1;
        g[G_MAIN] = 1'b1;
        g[G_TOSC] = t2a;
      end
      MODE_PWR_SAVE: begin
        g[G_ASY] = t2a;
        g[G_TOSC] = t2a;
      end
      MODE_STANDBY: begin
        g[G_MAIN] = 1'b1;
      end
      MODE_EXT_STANDBY: begin
        g[G_ASY] = t2a;
        g[G_MAIN] = 1'b1;
        g[G_TOSC] = t2a;
      end
      default: begin
        g = '0;
      end
    endcase
    return g;
  endfunction

  // pins from outside the clock domain; a short level may be missed
  sync2 #(.W(SYNC_N)) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .d({twi_addr_match, pin_change_irq, ext_irq_pin_b, ext_irq_pin_a, ext_reset_pin}),
    .q(pins_s)
  );

  // one counter serves start-up delay and core halt
  wake_counter u_cnt (
    .clk_sys(clk_sys),
    .reset(reset),
    .load(cnt_load),
    .load_val(cnt_val),
    .done(cnt_done)
  );

  // reserved codes, and standby codes without a crystal, are no-ops
  always_comb begin
    case (sleep_mode_select)
      MODE_RSVD_A, MODE_RSVD_B: mode_ok = 1'b0;
      MODE_STANDBY, MODE_EXT_STANDBY: mode_ok = crystal_clock_sel;
      default: mode_ok = 1'b1;
    endcase
  end
  assign go_sleep = (state_q == ST_ACTIVE) && sleep_instr && sleep_enable_bit && mode_ok;

  // wake source vector in index order
  assign src[W_EXT_A] = pins_s[S_EXT_A];
  assign src[W_EXT_B] = pins_s[S_EXT_B];
  assign src[W_PIN_CHG] = pins_s[S_PIN_CHG];
  assign src[W_TWI] = pins_s[S_TWI];
  assign src[W_WDT] = watchdog_irq;
  assign src[W_T2] = timer2_irq;
  assign src[W_STORE] = store_ready_irq;
  assign src[W_ADC] = adc_done_irq;
  assign src[W_OTHER] = other_irq;

  // sources each mode listens to
  always_comb begin
    mask = '0;
    t2_ok = 1'b0;
    case (mode_q)
      MODE_IDLE: begin
        mask = '1;
        t2_ok = timer2_async;
      end
      MODE_ADC_NR: begin
        mask[W_STORE] = 1'b1;
        mask[W_ADC] = 1'b1;
        t2_ok = timer2_async;
      end
      MODE_PWR_SAVE, MODE_EXT_STANDBY: begin
        t2_ok = 1'b1;
      end
      default: begin
        t2_ok = 1'b0;
      end
    endcase
    // common to every sleep mode, timer 2 gated by t2_ok
    mask[W_EXT_A] = 1'b1;
    mask[W_EXT_B] = 1'b1;
    mask[W_PIN_CHG] = 1'b1;
    mask[W_TWI] = 1'b1;
    mask[W_WDT] = 1'b1;
    mask[W_T2] = t2_ok;
    // outside idle, edge-configured pins never wake
    if (mode_q != MODE_IDLE) begin
      mask[W_EXT_A] = ext_irq_level_mode[0];
      mask[W_EXT_B] = ext_irq_level_mode[1];
    end
  end
  assign wake_vec = src & mask;
  assign wake_hit = |wake_vec;
  assign reset_hit = pins_s[S_RST] | watchdog_reset | brownout_reset;

  // start-up time per mode, stretched while the detector restarts
  assign pd_delay = PD_WAKE_BASE_P << clock_select_fuses[1:0];
  always_comb begin
    case (mode_q)
      MODE_STANDBY, MODE_EXT_STANDBY: startup_val = STANDBY_WAKE_CYCLES;
      MODE_PWR_DOWN, MODE_PWR_SAVE: startup_val = pd_delay;
      default: startup_val = IDLE_WAKE_CYCLES;
    endcase
    if (bod_off_q && (BOD_WAKE_CYCLES_P > startup_val)) begin
      startup_val = BOD_WAKE_CYCLES_P;
    end
  end

  // controller state machine
  always_comb begin
    state_d = state_q;
    cnt_load = 1'b0;
    cnt_val = startup_val;
    case (state_q)
      ST_ACTIVE: begin
        if (go_sleep) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (reset_hit || wake_hit) begin
          state_d = ST_WAKE;
          cnt_load = 1'b1;
        end
      end
      ST_WAKE: begin
        if (cnt_done && wake_reset_q) begin
          state_d = ST_ACTIVE;
        end else if (cnt_done) begin
          state_d = ST_HALT;
          cnt_load = 1'b1;
          cnt_val = HALT_CYCLES;
        end
      end
      ST_HALT: begin
        if (cnt_done) begin
          state_d = ST_ACTIVE;
        end
      end
      default: begin
        state_d = ST_ACTIVE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q <= ST_ACTIVE;
    end else begin
      state_q <= state_d;
    end
  end

  // mode held for the whole sleep so a later select change has no effect
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mode_q <= MODE_IDLE;
    end else if (go_sleep) begin
      mode_q <= sleep_mode_select;
    end
  end

  // remembers whether a reset caused the wake
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wake_reset_q <= 1'b0;
    end else if (state_q == ST_SLEEP) begin
      wake_reset_q <= reset_hit;
    end
  end

  // brown-out sleep disable bit, plain writes dropped
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      brownout_sleep_disable_q <= BROWNOUT_SLEEP_DISABLE_RST;
    end else if (mcu_ctrl_wr && mcu_ctrl_wr_qualified) begin
      brownout_sleep_disable_q <= mcu_ctrl_wdata[BROWNOUT_SLEEP_DISABLE_BIT];
    end
  end
  assign brownout_sleep_disable = brownout_sleep_disable_q;

  // detector only switched off in the deeper modes
  always_comb begin
    case (sleep_mode_select)
      MODE_PWR_DOWN, MODE_PWR_SAVE, MODE_STANDBY, MODE_EXT_STANDBY: bod_elig = brownout_sleep_disable_q;
      default: bod_elig = 1'b0;
    endcase
  end

  // detector off from entry, restored on the wake edge itself
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bod_en_q <= BOD_EN_RST;
      bod_off_q <= 1'b0;
    end else if (go_sleep) begin
      bod_en_q <= !bod_elig;
      bod_off_q <= bod_elig;
    end else if (state_q == ST_SLEEP && state_d == ST_WAKE) begin
      bod_en_q <= 1'b1;
    end else if (state_q == ST_ACTIVE) begin
      bod_off_q <= 1'b0;
    end
  end
  assign brownout_detector_en = bod_en_q;

  // clock gates lag the state by one cycle, acceptable for power gating
  always_comb begin
    case (state_q)
      ST_SLEEP: gate_d = gate_map(mode_q, timer2_async);
      ST_WAKE: gate_d = gate_map(mode_q, timer2_async) | (7'h01 << G_MAIN);
      ST_HALT: gate_d = GATE_RST & ~((7'h01 << G_CPU) | (7'h01 << G_FLASH));
      default: gate_d = GATE_RST;
    endcase
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      gate_q <= GATE_RST;
    end else begin
      gate_q <= gate_d;
    end
  end
  assign core_clock_en = gate_q[G_CPU];
  assign program_mem_clock_en = gate_q[G_FLASH];
  assign io_clock_en = gate_q[G_IO];
  assign converter_clock_en = gate_q[G_ADC];
  assign async_timer_clock_en = gate_q[G_ASY];
  assign main_osc_en = gate_q[G_MAIN];
  assign timer_osc_en = gate_q[G_TOSC];

  // comparator off by its bit, and always off in deep sleep
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      comp_en_q <= 1'b1;
    end else if (state_q == ST_SLEEP && mode_q != MODE_IDLE && mode_q != MODE_ADC_NR) begin
      comp_en_q <= 1'b0;
    end else begin
      comp_en_q <= !comparator_disable_bit;
    end
  end
  assign comparator_en = comp_en_q;

  // event pulses to core and converter
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      adc_start_q <= 1'b0;
      irq_resume_q <= 1'b0;
      reset_restart_q <= 1'b0;
    end else begin
      adc_start_q <= go_sleep && adc_enabled && (sleep_mode_select == MODE_IDLE ||
                     sleep_mode_select == MODE_ADC_NR);
      irq_resume_q <= (state_q == ST_HALT) && cnt_done;
      reset_restart_q <= (state_q == ST_WAKE) && cnt_done && wake_reset_q;
    end
  end
  assign adc_start = adc_start_q;
  assign irq_resume = irq_resume_q;
  assign reset_restart = reset_restart_q;
  assign sleeping = (state_q != ST_ACTIVE);

  // checks on the sequencing
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_nop_when_clear: assert property ((state_q == ST_ACTIVE && sleep_instr &&
    !sleep_enable_bit) |=> state_q == ST_ACTIVE) else $error("sleep taken without enable");
  a_idle_gates: assert property ((state_q == ST_SLEEP && mode_q == MODE_IDLE) ##1
    (state_q == ST_SLEEP) |-> (!core_clock_en && io_clock_en && converter_clock_en))
    else $error("idle gating wrong");
  a_adcnr_gates: assert property ((state_q == ST_SLEEP && mode_q == MODE_ADC_NR) ##1
    (state_q == ST_SLEEP) |-> (!io_clock_en && !core_clock_en && converter_clock_en))
    else $error("adc noise reduction gating wrong");
  a_pd_all_off: assert property ((state_q == ST_SLEEP && mode_q == MODE_PWR_DOWN) ##1
    (state_q == ST_SLEEP) |-> (gate_q == 7'h00)) else $error("power-down clock running");
  a_edge_pin_quiet: assert property ((state_q == ST_SLEEP && mode_q != MODE_IDLE &&
    !ext_irq_level_mode[0] && !reset_hit && src == 9'h001) |=> state_q == ST_SLEEP)
    else $error("edge pin woke device");
  a_halt_four: assert property ((state_q == ST_HALT && $past(state_q) != ST_HALT) |->
    (state_q == ST_HALT)[*4] ##1 (irq_resume && state_q == ST_ACTIVE))
    else $error("halt not four cycles");
  a_standby_six: assert property ((state_q == ST_SLEEP && state_d == ST_WAKE &&
    !bod_off_q && mode_q == MODE_STANDBY) |=> (state_q == ST_WAKE)[*6] ##1
    (state_q != ST_WAKE)) else $error("standby wake not six cycles");
  a_bod_idle_on: assert property ((state_q == ST_SLEEP && mode_q == MODE_IDLE) |->
    brownout_detector_en) else $error("detector off in idle");
  a_bod_sleep_off: assert property ((state_q == ST_SLEEP && bod_off_q) |->
    !brownout_detector_en) else $error("detector on while disabled");
  a_bod_wake_on: assert property ((state_q == ST_WAKE) |-> brownout_detector_en)
    else $error("detector not restored at wake");
  a_bod_long_wake: assert property ((state_q == ST_SLEEP && state_d == ST_WAKE &&
    bod_off_q) |=> (state_q == ST_WAKE)[*8]) else $error("detector wake too short");
  a_adc_autostart: assert property ((go_sleep && adc_enabled &&
    sleep_mode_select == MODE_ADC_NR) |=> adc_start) else $error("no conversion start");
  a_brownout_sleep_disable_plain_write: assert property ((mcu_ctrl_wr && !mcu_ctrl_wr_qualified) |=>
    $stable(brownout_sleep_disable)) else $error("plain write changed disable bit");
  a_reset_restart: assert property ((state_q == ST_WAKE && cnt_done && wake_reset_q) |=>
    (reset_restart && !irq_resume)) else $error("reset wake did not restart");

  c_idle_wake: cover property ((state_q == ST_HALT && mode_q == MODE_IDLE) ##[1:4] irq_resume);
  c_pd_reset_wake: cover property (state_q == ST_SLEEP && mode_q == MODE_PWR_DOWN && reset_hit);
  c_bod_off_sleep: cover property (state_q == ST_SLEEP && bod_off_q);
  c_standby_wake: cover property (state_q == ST_SLEEP && mode_q == MODE_STANDBY && wake_hit);
endmodule // sleep_mode_controller

// [rtl/sleep_pkg.sv]
// constants, modes and states shared by the sleep mode controller
package sleep_pkg;
  // sleep_mode_select encodings
  typedef enum logic [2:0] {
    MODE_IDLE = 3'b000,
    MODE_ADC_NR = 3'b001,
    MODE_PWR_DOWN = 3'b010,
    MODE_PWR_SAVE = 3'b011,
    MODE_RSVD_A = 3'b100,
    MODE_RSVD_B = 3'b101,
    MODE_STANDBY = 3'b110,
    MODE_EXT_STANDBY = 3'b111
  } sleep_mode_t;
  // controller states
  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_SLEEP = 2'b01,
    ST_WAKE = 2'b10,
    ST_HALT = 2'b11
  } sleep_state_t;
  // field position of brownout_sleep_disable in mcu_control_reg
  localparam int BROWNOUT_SLEEP_DISABLE_BIT = 6;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int BOD_WAKE_US = 60;
  localparam int BOD_WAKE_CYCLES = (BOD_WAKE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  localparam logic [15:0] HALT_CYCLES = 16'h0004;
  localparam logic [15:0] STANDBY_WAKE_CYCLES = 16'h0006;
  localparam logic [15:0] IDLE_WAKE_CYCLES = 16'h0001;
  localparam logic [15:0] PD_WAKE_BASE_CYCLES = 16'h0010;
  // wake source vector positions
  localparam int W_EXT_A = 0;
  localparam int W_EXT_B = 1;
  localparam int W_PIN_CHG = 2;
  localparam int W_TWI = 3;
  localparam int W_WDT = 4;
  localparam int W_T2 = 5;
  localparam int W_STORE = 6;
  localparam int W_ADC = 7;
  localparam int W_OTHER = 8;
  localparam int WAKE_N = 9;
  // synchronised pin vector positions
  localparam int S_RST = 0;
  localparam int S_EXT_A = 1;
  localparam int S_EXT_B = 2;
  localparam int S_PIN_CHG = 3;
  localparam int S_TWI = 4;
  localparam int SYNC_N = 5;
  // clock gate vector positions
  localparam int G_CPU = 0;
  localparam int G_FLASH = 1;
  localparam int G_IO = 2;
  localparam int G_ADC = 3;
  localparam int G_ASY = 4;
  localparam int G_MAIN = 5;
  localparam int G_TOSC = 6;
  localparam int GATE_N = 7;
  // reset values
  localparam logic [6:0] GATE_RST = 7'h7f;
  localparam logic BOD_EN_RST = 1'b1;
  localparam logic BROWNOUT_SLEEP_DISABLE_RST = 1'b0;
endpackage

// [rtl/sync2.sv]
// two flip-flop synchroniser for pin level inputs
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // async reset, high
  input wire logic [W-1:0] d, // asynchronous levels
  output logic [W-1:0] q // synchronised levels
);
  logic [W-1:0] meta_q;
  // first stage feeds only the second stage
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // sync2

// [rtl/wake_counter.sv]
// down counter timing start-up and halt intervals
`timescale 1ns/1ps
module wake_counter (
  input wire logic clk_sys, // system clock
  input wire logic reset, // async reset, high
  input wire logic load, // load interval length
  input wire logic [15:0] load_val, // interval in cycles
  output logic done // last cycle of interval
);
  logic [15:0] count_q;
  // load n gives done in the n-th cycle after loading
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count_q <= 16'h0000;
    end else if (load) begin
      count_q <= load_val;
    end else if (count_q != 16'h0000) begin
      count_q <= count_q - 16'h0001;
    end
  end
  assign done = (count_q <= 16'h0001);
endmodule // wake_counter

// [tb/core_model.sv]
// processor core and wake source model on the controller's far side
`timescale 1ns/1ps
module core_model (
  input wire logic clk_sys, // system clock
  input wire logic sleep_req, // bench asks for a sleep instruction
  input wire logic fire, // bench asks for a wake event
  input wire logic [3:0] src, // which wake line
  output logic sleep_instr, // one-cycle sleep instruction
  output logic [11:0] lines // wake and reset lines
);
  logic [2:0] hold_q = 3'h0;
  // the core issues the instruction for exactly one cycle
  always @(posedge clk_sys) sleep_instr <= sleep_req;
  // async pins hold four cycles, enough to cross the synchroniser
  always @(posedge clk_sys) begin
    if (fire) begin
      lines <= 12'h001 << src;
      hold_q <= (src < 4'h5) ? 3'h3 : 3'h0;
    end else if (hold_q != 3'h0) begin
      hold_q <= hold_q - 3'h1;
    end else begin
      lines <= 12'h000;
    end
  end
endmodule // core_model

// [tb/tb.sv]
// self-checking bench for the sleep mode controller
`timescale 1ns/1ps
module tb;
  import sleep_pkg::*;
  logic clk_sys, reset, se, sreq, fire, wr, qual, xtal, t2a, adc_en, cdis, si, brownout_sleep_disable_x;
  logic bod_en, brownout_sleep_disable_o, cmp_en, adc_start, irq_resume, reset_restart, sleeping;
  logic [2:0] m_q;
  logic [3:0] src, fuses;
  logic [1:0] lvl;
  logic [7:0] wdata;
  logic [11:0] ln;
  logic [6:0] g;
  logic [31:0] r;
  int mismatches = 0;
  int n_tests = 0;
  int n_adc = 0;
  int seed = 38621;
  // short counts keep the run brief: detector wake 20, power-down base 2
  sleep_mode_controller #(.BOD_WAKE_CYCLES_P(16'h0014), .PD_WAKE_BASE_P(16'h0002))
    sleep_mode_controller_i (.clk_sys(clk_sys), .reset(reset), .sleep_enable_bit(se),
    .sleep_mode_select(sleep_mode_t'(m_q)), .sleep_instr(si), .mcu_ctrl_wr(wr),
    .mcu_ctrl_wr_qualified(qual), .mcu_ctrl_wdata(wdata), .crystal_clock_sel(xtal),
    .clock_select_fuses(fuses), .timer2_async(t2a), .adc_enabled(adc_en),
    .comparator_disable_bit(cdis), .ext_irq_level_mode(lvl), .ext_reset_pin(ln[0]),
    .ext_irq_pin_a(ln[1]), .ext_irq_pin_b(ln[2]), .pin_change_irq(ln[3]),
    .twi_addr_match(ln[4]), .watchdog_irq(ln[5]), .watchdog_reset(ln[6]),
    .brownout_reset(ln[7]), .timer2_irq(ln[8]), .store_ready_irq(ln[9]),
    .adc_done_irq(ln[10]), .other_irq(ln[11]), .core_clock_en(g[G_CPU]),
    .program_mem_clock_en(g[G_FLASH]), .io_clock_en(g[G_IO]),
    .converter_clock_en(g[G_ADC]), .async_timer_clock_en(g[G_ASY]),
    .main_osc_en(g[G_MAIN]), .timer_osc_en(g[G_TOSC]), .brownout_detector_en(bod_en),
    .brownout_sleep_disable(brownout_sleep_disable_o), .comparator_en(cmp_en), .adc_start(adc_start),
    .irq_resume(irq_resume), .reset_restart(reset_restart), .sleeping(sleeping));
  core_model core_model_i (.clk_sys(clk_sys), .sleep_req(sreq), .fire(fire), .src(src),
    .sleep_instr(si), .lines(ln));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (adc_start === 1'b1) n_adc++;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // wake qualification per mode, reset sources always win
  function automatic logic allow(input logic [2:0] m, input logic [3:0] s);
    case (s)
      4'h1, 4'h2: return m == 3'h0 || lvl[s-4'h1];
      4'h8: return (m < 3'h2) ? t2a : m[0];
      4'h9, 4'ha: return m < 3'h2;
      4'hb: return m == 3'h0;
      default: return 1'b1;
    endcase
  endfunction
  // clocks left running per mode; timer oscillator follows asynchronous timer 2 outside power-down and standby
  function automatic logic [6:0] gexp(input logic [2:0] m);
    case (m)
      3'h0: return {t2a, 6'h3c};
      3'h1: return {t2a, 6'h38};
      3'h2: return 7'h00;
      3'h3: return {t2a, 1'b0, t2a, 4'h0};
      3'h6: return 7'h20;
      default: return {t2a, 1'b1, t2a, 4'h0};
    endcase
  endfunction
  // cycles from fire to irq_resume: start-up plus four halt plus pipeline
  function automatic int lat(input logic [2:0] m);
    int n;
    n = (m < 3'h2) ? 1 : m[2] ? 6 : (2 << fuses[1:0]);
    if (m > 3'h1 && brownout_sleep_disable_x && n < 20) n = 20;
    return n + 6;
  endfunction
  task automatic wr_brownout_sleep_disable(input logic v, input logic q);
    @(posedge clk_sys);
    wr <= 1'b1;
    qual <= q;
    wdata <= {1'b0, v, 6'h2a};
    @(posedge clk_sys);
    wr <= 1'b0;
    qual <= 1'b0;
    if (q) brownout_sleep_disable_x = v;
    @(negedge clk_sys);
    chk(brownout_sleep_disable_o, brownout_sleep_disable_x);
  endtask
  task automatic fire_src(input logic [3:0] s);
    @(posedge clk_sys);
    src <= s;
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
  endtask
  task automatic sw(input logic [2:0] m, input logic [3:0] s);
    logic rsv;
    logic ok;
    int j;
    int a0;
    @(posedge clk_sys);
    rsv = m[2:1] == 2'b10 || (m[2:1] == 2'b11 && !xtal) || !se;
    ok = allow(m, s);
    a0 = n_adc;
    m_q <= m;
    sreq <= 1'b1;
    @(posedge clk_sys);
    sreq <= 1'b0;
    repeat (4) @(negedge clk_sys);
    chk(sleeping, !rsv);
    chk(16'(n_adc - a0), adc_en && m < 3'h2 && !rsv);
    chk(cmp_en, !cdis && (m < 3'h2 || rsv));
    if (!rsv) begin
      chk(g, gexp(m));
      chk(bod_en, !(brownout_sleep_disable_x && m > 3'h1));
      fire_src(s);
      if (!ok) begin
        repeat (30) @(negedge clk_sys);
        chk(sleeping, 1'b1);
        s = 4'h5;
        fire_src(s);
      end
      j = 0;
      while (irq_resume !== 1'b1 && reset_restart !== 1'b1 && j < 200) begin
        @(negedge clk_sys);
        j++;
      end
      if (s == 4'h5) chk(16'(j), 16'(lat(m)));
      chk(reset_restart, s == 4'h0 || s == 4'h6 || s == 4'h7);
      chk({sleeping, bod_en}, 2'b01);
    end
  endtask
  initial begin
    {reset, se, xtal, t2a} = 4'hf;
    {sreq, fire, wr, qual, adc_en, cdis, brownout_sleep_disable_x} = 7'h00;
    {m_q, src, fuses, lvl, wdata} = 21'h0;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    wr_brownout_sleep_disable(1'b1, 1'b0);
    wr_brownout_sleep_disable(1'b1, 1'b1);
    sw(3'h2, 4'h5);
    sw(3'h0, 4'h5);
    wr_brownout_sleep_disable(1'b0, 1'b1);
    for (int m = 0; m < 8; m++) sw(3'(m), 4'h5);
    // edge-set pins, listed-only sources and a reset wake
    sw(3'h2, 4'h1);
    sw(3'h0, 4'h1);
    sw(3'h1, 4'hb);
    sw(3'h2, 4'ha);
    sw(3'h6, 4'h8);
    sw(3'h1, 4'h0);
    repeat (40) begin
      r = $random(seed);
      @(posedge clk_sys);
      {t2a, lvl, adc_en, fuses, cdis} <= r[8:0];
      xtal <= r[10] | r[11];
      se <= r[12] | r[13];
      if (r[14]) wr_brownout_sleep_disable(r[15], r[16]);
      sw(r[19:17], 4'(r[23:20] % 12));
    end
    stop_test();
  end
  initial begin
    #200000;
    mismatches++;
    stop_test();
  end
endmodule // tb
